// [pkg/ocp_pkg.sv]
// package: register map, field positions and modes of the output compare pwm channel
package ocp_pkg;
  // register byte addresses; the 4 bit bus leaves no fifth word, so period sits off grid
  localparam logic [3:0] ADDR_CTRL_PRI = 4'h0;
  localparam logic [3:0] ADDR_CTRL_SEC = 4'h4;
  localparam logic [3:0] ADDR_CMP_PRI = 4'h8;
  localparam logic [3:0] ADDR_CMP_SEC = 4'hc;
  localparam logic [3:0] ADDR_PERIOD = 4'h2;
  // primary control field positions
  localparam int POS_IDLE_HALT = 13;
  localparam int POS_TSEL_LO = 10;
  localparam int POS_FLT_EN = 7;
  localparam int POS_FLT_STAT = 4;
  localparam int POS_TRIG_CLR = 3;
  // secondary control field positions
  localparam int POS_FLT_EXIT = 15;
  localparam int POS_FLT_LVL = 14;
  localparam int POS_FLT_DIR = 13;
  localparam int POS_INV = 12;
  localparam int POS_CASCADE = 8;
  localparam int POS_TRIG_SEL = 7;
  localparam int POS_TRIG_STAT = 6;
  localparam int POS_TRIS = 5;
  // writable masks and reset values
  localparam logic [15:0] MASK_CTRL_PRI = 16'h3c8f;
  localparam logic [15:0] MASK_CTRL_SEC = 16'hf1ff;
  localparam logic [15:0] RST_CTRL_PRI = 16'h0000;
  localparam logic [15:0] RST_CTRL_SEC = 16'h000c;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [4:0] SYNC_NONE = 5'h00;
  localparam logic [4:0] SYNC_SELF = 5'h1f;
  localparam logic [2:0] TSEL_PCLK = 3'h7;
  typedef enum logic [2:0] {
    OCP_MODE_OFF = 3'h0,
    OCP_MODE_SS_HI = 3'h1,
    OCP_MODE_SS_LO = 3'h2,
    OCP_MODE_TOGGLE = 3'h3,
    OCP_MODE_DBL_SS = 3'h4,
    OCP_MODE_DBL_CONT = 3'h5,
    OCP_MODE_PWM_EDGE = 3'h6,
    OCP_MODE_PWM_CTR = 3'h7
  } ocp_mode_type;
  // avalon request carried as one bundle
  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
  } ocp_req_type;
endpackage : ocp_pkg

// [core/ocp_channel.sv]
// file: output compare / pwm channel with avalon-mm register slave
//
// Implementation choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
module ocp_channel
  import ocp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic cpu_idle,
  input wire logic [4:0] timer_tick,
  input wire logic [31:0] sync_sources,
  input wire logic fault_in,
  input wire logic cascade_carry_in,
  output logic cascade_carry_out,
  output logic channel_output,
  output logic channel_output_oe,
  output logic channel_interrupt_flag,
  output logic sync_event_out
);
  logic [15:0] compare_control_primary;
  logic [15:0] compare_control_secondary;
  logic [15:0] primary_compare_value;
  logic [15:0] secondary_compare_value;
  logic [15:0] period_value;
  logic [15:0] duty_pri;
  logic [15:0] duty_sec;
  logic [15:0] internal_channel_counter;
  logic wave;
  logic fault_active;
  logic fault_status_flag;
  logic trigger_status;
  logic served;
  logic armed;

  ocp_req_type req;
  assign req = '{read: avs_read, write: avs_write, address: avs_address,
                 writedata: avs_writedata};

  // decoded control fields
  wire ocp_mode_type mode = ocp_mode_type'(compare_control_primary[2:0]);
  wire [2:0] time_base_select = compare_control_primary[POS_TSEL_LO +: 3];
  wire idle_halt_bit = compare_control_primary[POS_IDLE_HALT];
  wire fault_input_enable = compare_control_primary[POS_FLT_EN];
  wire trigger_clear_mode = compare_control_primary[POS_TRIG_CLR];
  wire fault_exit_mode = compare_control_secondary[POS_FLT_EXIT];
  wire fault_output_level = compare_control_secondary[POS_FLT_LVL];
  wire fault_force_direction = compare_control_secondary[POS_FLT_DIR];
  wire output_invert = compare_control_secondary[POS_INV];
  wire cascade_pair_enable = compare_control_secondary[POS_CASCADE];
  wire trigger_or_sync_select = compare_control_secondary[POS_TRIG_SEL];
  wire output_tristate = compare_control_secondary[POS_TRIS];
  wire [4:0] sync_source_select = compare_control_secondary[4:0];

  // bus decode; one wait cycle then answer
  wire access = (req.read | req.write) & ~served;
  // writes land at the edge where waitrequest stands low, not at the taking edge
  wire commit = req.write & served;
  wire wr_pri = commit & (req.address == ADDR_CTRL_PRI);
  wire wr_sec = commit & (req.address == ADDR_CTRL_SEC);
  wire wr_cmp = commit & (req.address == ADDR_CMP_PRI);
  wire wr_cms = commit & (req.address == ADDR_CMP_SEC);
  wire wr_per = commit & (req.address == ADDR_PERIOD);
  wire is_pwm = (mode == OCP_MODE_PWM_EDGE) | (mode == OCP_MODE_PWM_CTR);

  // time base tick: peripheral clock or one of five timers, reserved codes stall
  wire tb_tick = (time_base_select == TSEL_PCLK) ? 1'b1 :
                 (time_base_select == 3'h4) ? timer_tick[0] :
                 (time_base_select == 3'h3) ? timer_tick[4] :
                 (time_base_select == 3'h2) ? timer_tick[3] :
                 (time_base_select == 3'h1) ? timer_tick[2] :
                 (time_base_select == 3'h0) ? timer_tick[1] : 1'b0;
  wire halted = idle_halt_bit & cpu_idle;
  // cascade: high half only advances on carry from the low half
  wire step = ~halted & (cascade_pair_enable ? cascade_carry_in : tb_tick);
  wire sync_hit = (sync_source_select != SYNC_NONE) & sync_sources[sync_source_select];
  wire use_trig = (sync_source_select != SYNC_NONE) & trigger_or_sync_select;
  wire self_sync = (sync_source_select == SYNC_SELF);
  wire per_match = (internal_channel_counter == period_value);
  wire pri_match = step & (internal_channel_counter == duty_pri);
  wire sec_match = step & (internal_channel_counter == duty_sec);
  wire fault_seen = fault_input_enable & fault_in;
  wire running = (mode != OCP_MODE_OFF) & (~use_trig | trigger_status);
  // period ends at period match when self-synced or in pwm, else plain wrap
  wire period_end = step & per_match & (is_pwm | self_sync);
  wire sync_clear = step & ~use_trig & sync_hit & ~self_sync;
  wire [15:0] next_cnt = (~running | sync_clear | period_end) ? CNT_ZERO :
                         step ? 16'(internal_channel_counter + 16'h0001) :
                         internal_channel_counter;
  wire wrap = step & running & (internal_channel_counter == CNT_MAX);
  wire trig_set = use_trig & sync_hit;
  wire trig_clr_hw = trigger_clear_mode & sec_match;
  wire trig_clr_sw = wr_sec & ~req.writedata[POS_TRIG_STAT];
  wire fault_clr_sw = wr_pri & ~req.writedata[POS_FLT_STAT];
  wire fault_release = ~fault_seen &
                       (fault_exit_mode ? (fault_clr_sw | ~fault_status_flag) : period_end);

  // register file and status bits
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      compare_control_primary <= RST_CTRL_PRI;
      compare_control_secondary <= RST_CTRL_SEC;
      primary_compare_value <= CNT_ZERO;
      secondary_compare_value <= CNT_ZERO;
      period_value <= CNT_MAX;
      trigger_status <= 1'b0;
      fault_status_flag <= 1'b0;
    end
    else
    begin
      if (wr_pri)
        compare_control_primary <= (req.writedata[15:0] & MASK_CTRL_PRI)
          | (compare_control_primary & ~MASK_CTRL_PRI);
      else
        compare_control_primary <= compare_control_primary;
      if (wr_sec)
        compare_control_secondary <= (req.writedata[15:0] & MASK_CTRL_SEC)
          | (compare_control_secondary & ~MASK_CTRL_SEC);
      if (wr_cmp)
        primary_compare_value <= req.writedata[15:0];
      if (wr_cms)
        secondary_compare_value <= req.writedata[15:0];
      if (wr_per)
        period_value <= req.writedata[15:0];
      // set wins over any clear
      if (trig_set)
        trigger_status <= 1'b1;
      else if (trig_clr_hw | trig_clr_sw | ~use_trig)
        trigger_status <= 1'b0;
      // flag only meaningful in center aligned pwm; software write of zero
      // only ends a latched fault, it is not a general clear
      if (fault_seen & (mode == OCP_MODE_PWM_CTR))
        fault_status_flag <= 1'b1;
      else if (fault_exit_mode & fault_clr_sw & ~fault_seen)
        fault_status_flag <= 1'b0;
      else if (~fault_exit_mode & period_end & ~fault_seen)
        fault_status_flag <= 1'b0;
    end
  end

  // counter and duty shadow
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      internal_channel_counter <= CNT_ZERO;
      duty_pri <= CNT_ZERO;
      duty_sec <= CNT_ZERO;
      cascade_carry_out <= 1'b0;
    end
    else
    begin
      internal_channel_counter <= next_cnt;
      cascade_carry_out <= wrap;
      if (~is_pwm | (step & per_match))
      begin
        duty_pri <= primary_compare_value;
        duty_sec <= secondary_compare_value;
      end
    end
  end

  // waveform generation per mode
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      wave <= 1'b0;
      armed <= 1'b0;
      fault_active <= 1'b0;
      channel_interrupt_flag <= 1'b0;
    end
    else
    begin
      channel_interrupt_flag <= 1'b0;
      if (fault_seen & is_pwm)
        fault_active <= 1'b1;
      else if (fault_release)
        fault_active <= 1'b0;
      if (wr_pri)
      begin
        // rewriting the mode rearms a single shot
        armed <= 1'b1;
        wave <= (ocp_mode_type'(req.writedata[2:0]) == OCP_MODE_SS_LO);
      end
      else
      begin
        unique case (mode)
          OCP_MODE_OFF:
            wave <= 1'b0;
          OCP_MODE_SS_HI, OCP_MODE_SS_LO:
            if (armed & pri_match & running)
            begin
              wave <= (mode == OCP_MODE_SS_HI);
              armed <= 1'b0;
              channel_interrupt_flag <= 1'b1;
            end
          OCP_MODE_TOGGLE:
            if (pri_match & running)
            begin
              wave <= ~wave;
              channel_interrupt_flag <= 1'b1;
            end
          OCP_MODE_DBL_SS, OCP_MODE_DBL_CONT:
            if (running & (armed | mode == OCP_MODE_DBL_CONT))
            begin
              if (pri_match)
                wave <= 1'b1;
              else if (sec_match)
              begin
                wave <= 1'b0;
                armed <= 1'b0;
                channel_interrupt_flag <= 1'b1;
              end
            end
          OCP_MODE_PWM_EDGE, OCP_MODE_PWM_CTR:
            if (running & step)
            begin
              // high from primary match until secondary match
              if (duty_sec > period_value)
                wave <= 1'b1;
              else if (duty_pri == CNT_ZERO & duty_sec == CNT_ZERO)
                wave <= 1'b0;
              else if (sec_match)
              begin
                wave <= 1'b0;
                channel_interrupt_flag <= 1'b1;
              end
              else if (pri_match)
                wave <= 1'b1;
            end
        endcase
      end
    end
  end

  // pin and bus outputs, all registered
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      channel_output <= 1'b0;
      channel_output_oe <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
      served <= 1'b0;
      sync_event_out <= 1'b0;
    end
    else
    begin
      channel_output <= fault_active ? fault_output_level : (wave ^ output_invert);
      channel_output_oe <= ~output_tristate | (fault_active & fault_force_direction);
      sync_event_out <= period_end | wrap;
      served <= access;
      avs_waitrequest <= ~access;
      unique case (req.address)
        ADDR_CTRL_PRI: avs_readdata <= {16'h0000, compare_control_primary[15:5],
                                        fault_status_flag, compare_control_primary[3:0]};
        ADDR_CTRL_SEC: avs_readdata <= {16'h0000, compare_control_secondary[15:7],
                                        trigger_status, compare_control_secondary[5:0]};
        ADDR_CMP_PRI: avs_readdata <= {16'h0000, primary_compare_value};
        ADDR_CMP_SEC: avs_readdata <= {16'h0000, secondary_compare_value};
        ADDR_PERIOD: avs_readdata <= {16'h0000, period_value};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // assertions
  property p_out_fault;
    @(posedge clk_sys) disable iff (!rst_b)
    fault_active |=> channel_output == $past(fault_output_level);
  endproperty
  a_out_fault: assert property (p_out_fault) else $error("fault level not driven");
  property p_oe;
    @(posedge clk_sys) disable iff (!rst_b)
    (output_tristate & ~fault_active) |=> ~channel_output_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("pin not tristated");
  property p_halt;
    @(posedge clk_sys) disable iff (!rst_b)
    (halted & running & ~period_end & ~sync_clear) |=> $stable(internal_channel_counter);
  endproperty
  a_halt: assert property (p_halt) else $error("counter moved in idle");
  property p_trig_hold;
    @(posedge clk_sys) disable iff (!rst_b)
    (use_trig & ~trigger_status & mode != OCP_MODE_OFF) |=> internal_channel_counter == CNT_ZERO;
  endproperty
  a_trig_hold: assert property (p_trig_hold) else $error("counter ran untriggered");
  property p_flt_ignored;
    @(posedge clk_sys) disable iff (!rst_b)
    (~fault_input_enable & ~fault_status_flag) |=> ~$rose(fault_status_flag);
  endproperty
  a_flt_ignored: assert property (p_flt_ignored) else $error("fault taken while off");
  property p_wrap;
    @(posedge clk_sys) disable iff (!rst_b)
    wrap & ~sync_clear |=> internal_channel_counter == CNT_ZERO;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");
  property p_shadow;
    @(posedge clk_sys) disable iff (!rst_b)
    (is_pwm & ~(step & per_match)) |=> $stable(duty_sec);
  endproperty
  a_shadow: assert property (p_shadow) else $error("duty changed mid period");
  property p_wait;
    @(posedge clk_sys) disable iff (!rst_b)
    access |=> ~avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer timing");
  c_pwm: cover property (@(posedge clk_sys) disable iff (!rst_b) is_pwm & sec_match);
  c_fault: cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(fault_active));
  c_trig: cover property (@(posedge clk_sys) disable iff (!rst_b) trig_set);
endmodule : ocp_channel

// [sim/ocp_power_stage.sv]
// external power stage model: sees the channel pin, reports a fault back
`timescale 1ns/100ps
module ocp_power_stage
(
  input wire logic clk_sys,
  input wire logic drive,
  input wire logic drive_en,
  input wire logic trip_req,
  output logic pin_level,
  output logic fault_out
);
  // pin has a pull-down, so a released pin reads low, never the last value
  assign pin_level = drive_en ? drive : 1'b0;
  // fault line is registered like a real comparator latch in the stage
  always_ff @(posedge clk_sys)
  begin
    fault_out <= trip_req;
  end
endmodule : ocp_power_stage

// [sim/tb_top.sv]
// testbench: register, compare-mode and fault checks of the channel
`timescale 1ns/100ps
module tb_top;
  import ocp_pkg::*;
  logic clk_sys;
  logic rst_b;
  logic [3:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic fault_in;
  logic cascade_carry_out;
  logic channel_output;
  logic channel_output_oe;
  logic channel_interrupt_flag;
  logic sync_event_out;
  logic pin_level;
  logic trip_req;
  int err_total;
  int comparisons;
  int irq_cnt;
  logic [31:0] rd;

  ocp_channel u_ocp_channel (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .cpu_idle(1'b0),
    .timer_tick(5'h00),
    .sync_sources(32'h00000000),
    .fault_in(fault_in),
    .cascade_carry_in(1'b0),
    .cascade_carry_out(cascade_carry_out),
    .channel_output(channel_output),
    .channel_output_oe(channel_output_oe),
    .channel_interrupt_flag(channel_interrupt_flag),
    .sync_event_out(sync_event_out)
  );

  ocp_power_stage u_ocp_power_stage (
    .clk_sys(clk_sys),
    .drive(channel_output),
    .drive_en(channel_output_oe),
    .trip_req(trip_req),
    .pin_level(pin_level),
    .fault_out(fault_in)
  );

  // 25 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // interrupt pulses are counted so a missed one-cycle pulse is still seen
  always @(posedge clk_sys)
  begin
    if (channel_interrupt_flag === 1'b1)
      irq_cnt <= irq_cnt + 1;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic summarize;
    if (err_total == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  // one avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] data);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= addr;
    avs_writedata <= data;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100)
      err_total++;
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  // bounded wait for the output to reach a level
  task automatic wait_out(input logic lvl, input int limit);
    int n;
    n = 0;
    while (channel_output !== lvl && n < limit)
    begin
      @(posedge clk_sys);
      n++;
    end
  endtask : wait_out

  initial
  begin
    rst_b = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    trip_req = 1'b0;
    err_total = 0;
    comparisons = 0;
    irq_cnt = 0;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    // reset values of both control words and write mask of the primary
    bus(1'b0, ADDR_CTRL_PRI, 32'h0);
    check("ctrl_pri_rst", rd, {16'h0000, RST_CTRL_PRI});
    bus(1'b0, ADDR_CTRL_SEC, 32'h0);
    check("ctrl_sec_rst", rd, {16'h0000, RST_CTRL_SEC});
    bus(1'b1, ADDR_CTRL_PRI, 32'hffff3c08);
    bus(1'b0, ADDR_CTRL_PRI, 32'h0);
    check("ctrl_pri_mask", rd, 32'h00003c08);
    bus(1'b1, ADDR_CTRL_PRI, 32'h00000000);
    // compare values land directly outside pwm modes
    bus(1'b1, ADDR_CMP_PRI, 32'h00000008);
    bus(1'b1, ADDR_CMP_SEC, 32'hffffa5c3);
    bus(1'b0, ADDR_CMP_SEC, 32'h0);
    check("cmp_sec", rd, 32'h0000a5c3);
    bus(1'b0, ADDR_CMP_PRI, 32'h0);
    check("cmp_pri", rd, 32'h00000008);
    bus(1'b0, 4'h6, 32'h0);
    check("unmapped", rd, 32'h00000000);
    // control writes must not reach the period register
    bus(1'b0, ADDR_PERIOD, 32'h0);
    check("period_rst", rd, {16'h0000, CNT_MAX});
    // timer two selected but never ticks: single shot must not fire
    bus(1'b1, ADDR_CTRL_PRI, 32'h00000001);
    repeat (200) @(posedge clk_sys);
    check("tsel_t2_idle", {31'h0, channel_output}, 32'h0);
    check("oe_tris_off", {31'h0, channel_output_oe}, 32'h1);
    // peripheral clock: single shot low-to-high on the primary match
    irq_cnt = 0;
    bus(1'b1, ADDR_CTRL_PRI, 32'h00001c01);
    wait_out(1'b1, 70000);
    check("ss_hi", {31'h0, channel_output}, 32'h1);
    check("irq_seen", {31'h0, irq_cnt > 0}, 32'h1);
    // invert complements the held level
    bus(1'b1, ADDR_CTRL_SEC, 32'h0000100c);
    repeat (4) @(posedge clk_sys);
    check("inv", {31'h0, channel_output}, 32'h0);
    // fault ignored while the enable bit is clear; pin tristated
    bus(1'b1, ADDR_CTRL_SEC, 32'h0000e020);
    bus(1'b1, ADDR_CTRL_PRI, 32'h00001c07);
    trip_req <= 1'b1;
    repeat (6) @(posedge clk_sys);
    bus(1'b0, ADDR_CTRL_PRI, 32'h0);
    check("flt_disabled", rd, 32'h00001c07);
    check("oe_tris_on", {31'h0, channel_output_oe}, 32'h0);
    // enabled fault: flag set, level driven, pin forced to output
    bus(1'b1, ADDR_CTRL_PRI, 32'h00001c87);
    repeat (6) @(posedge clk_sys);
    check("flt_out", {31'h0, channel_output}, 32'h1);
    check("flt_oe", {31'h0, channel_output_oe}, 32'h1);
    check("flt_pin", {31'h0, pin_level}, 32'h1);
    bus(1'b0, ADDR_CTRL_PRI, 32'h0);
    check("flt_flag", rd, 32'h00001c97);
    // exit mode one: flag stays after removal until software clears it
    trip_req <= 1'b0;
    repeat (6) @(posedge clk_sys);
    bus(1'b0, ADDR_CTRL_PRI, 32'h0);
    check("flt_hold", rd, 32'h00001c97);
    bus(1'b1, ADDR_CTRL_PRI, 32'h00001c87);
    bus(1'b0, ADDR_CTRL_PRI, 32'h0);
    check("flt_clear", rd, 32'h00001c87);
    summarize();
  end

  // hang guard sized well past the longest single-shot wait
  initial
  begin
    repeat (95000) @(posedge clk_sys);
    err_total++;
    summarize();
  end
endmodule : tb_top
